// File: ccs_pkg.sv
// Purpose: shared constants and types for the processor clock-state controller
// Assumes: one 100 MHz clock shared by both ends of the link
// Notes: state codes are one-hot; counts are derived from printed times
package ccs_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_MHZ = 100;
   localparam int EXIT_BUS_CLKS = 10;            // exit latency in bus clocks
   localparam int SNOOP_EXIT_CLKS = 2;           // "a few" clocks after snoop ends
   localparam real PLL_LOCK_US = 30.0;           // lock delay after clocks restart
   localparam int PLL_LOCK_CYC = int'(PLL_LOCK_US * CLK_MHZ);
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] EXIT_CNT = CNT_W'(EXIT_BUS_CLKS);
   localparam logic [CNT_W-1:0] SNOOP_CNT = CNT_W'(SNOOP_EXIT_CLKS);
   localparam logic [CNT_W-1:0] LOCK_CNT = CNT_W'(PLL_LOCK_CYC);

   // ==========================================================
   // event vector bit positions
   localparam int EV_NMI = 0;
   localparam int EV_IRQ = 1;
   localparam int EV_INIT = 2;
   localparam int EV_MGMT = 3;
   localparam int EV_BUS_INIT = 4;
   localparam int EV_FLUSH = 5;
   localparam int EV_RESET = 6;
   localparam int EV_W = 7;
   localparam int PEND_W = 4;                    // latchable interrupt events

   // ==========================================================
   // clock states
   typedef enum logic [6:0] {
      CCS_NORMAL      = 7'h01,
      CCS_AUTO_HALT   = 7'h02,
      CCS_STOP_GRANT  = 7'h04,
      CCS_QUICK_START = 7'h08,
      CCS_SNOOP       = 7'h10,
      CCS_SLEEP       = 7'h20,
      CCS_DEEP_SLEEP  = 7'h40
   } ccs_state_t;
endpackage : ccs_pkg

// File: ccs_link_if.sv
// Purpose: link between the processor clock-state controller and the system logic
// Assumes: both ends run on the same clock; active-low names end in _n
// Notes: no clocking block; the testbench joins the two ends through this
`timescale 1ns/1ps
interface ccs_link_if;
   import ccs_pkg::*;
   // system to device
   logic stop_clock_request_n;
   logic sleep_request_n;
   logic quick_start_strap_n;
   logic sys_reset_n;
   logic bus_clock_on;
   logic maskable_irq_ctrl_clock_on;
   logic priority_bus_request_n;
   logic snoop_req;
   logic [EV_W-2:0] events;      // nmi, irq, init, mgmt irq, bus init, flush (active high)
   logic addr20_mask_n;
   logic probe_request_n;
   // device to system
   ccs_state_t clk_state;
   logic stop_grant_ack;
   logic halt_cycle;
   logic snoop_busy;

   modport dev (
      input stop_clock_request_n, sleep_request_n, quick_start_strap_n, sys_reset_n,
      input bus_clock_on, maskable_irq_ctrl_clock_on, priority_bus_request_n, snoop_req,
      input events, addr20_mask_n, probe_request_n,
      output clk_state, stop_grant_ack, halt_cycle, snoop_busy
   );
   modport sys (
      output stop_clock_request_n, sleep_request_n, quick_start_strap_n, sys_reset_n,
      output bus_clock_on, maskable_irq_ctrl_clock_on, priority_bus_request_n, snoop_req,
      output events, addr20_mask_n, probe_request_n,
      input clk_state, stop_grant_ack, halt_cycle, snoop_busy
   );
endinterface : ccs_link_if

// File: ccs_dev.sv
// Purpose: processor clock-state controller, device end of the link
// Assumes: link inputs come from logic on core_clk_i, so no synchronisers
// Notes: bus clock stop is seen as bus_clock_on low; the core keeps ticking
// Behaviour
// - seven clock states, only documented transitions
// - deep sleep returns after 30 us lock
// - strap picks quick start or stop grant
// - halt enters auto halt; break events exit
// - exits take ten bus clocks, snoop exits two; snoop entry immediate
// - stop request in auto halt acknowledges
// - stop removed returns to auto halt silently
// - management irq in halt, return either way
// - flush serviced in halt; mask, probe seen
// - stop grant snoops, latches one of each
// - stop grant exits: stop, bus init, flush
// - reset in stop grant or quick start keeps that state
// - system changes few inputs in quick start
// - no interrupt messages during quick start
// - system stops bus clock low for deep sleep
// - quick start leaves only on stop removal
// - snoops serviced then return to prior state
// - sleep only from stop grant
// - system drops sleep, stop on reset
// - inputs steady in sleep; no deep reset
// - interrupt clock stops with bus clock and in sleep; restarts together only out of quick start
// - quick start only for single processor
`timescale 1ns/1ps
module ccs_dev
   import ccs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // link
   ccs_link_if.dev link,
   // core side
   input wire logic halt_instruction_i,
   input wire logic mgmt_exit_i,
   input wire logic mgmt_to_halt_i,
   input wire logic flush_done_i,
   output logic core_clk_run_o,
   output logic sys_mgmt_mode_o,
   output logic flush_busy_o,
   output logic addr20_mask_o,
   output logic probe_seen_o,
   output logic svc_o,
   output logic [PEND_W-1:0] svc_events_o
);
   // ==========================================================
   // state record
   typedef struct packed {
      ccs_state_t st;
      ccs_state_t prev;       // state to return to after snoop or deep sleep
      ccs_state_t tgt;        // target of a timed exit
      logic exiting;
      logic [CNT_W-1:0] cnt;
      logic strap_qs;
      logic strap_done;
      logic from_halt;        // low-power state was entered from auto halt
      logic mgmt;
      logic flushing;
      logic [EV_W-1:0] ev_q;
      logic [PEND_W-1:0] pend;
      logic addr_mask;
      logic probe_q;
      logic probe_seen;
      logic grant_ack;
      logic halt_cyc;
      logic svc;
      logic [PEND_W-1:0] svc_ev;
   } ccs_dev_t;

   localparam ccs_dev_t RST = '{st: CCS_NORMAL, prev: CCS_NORMAL, tgt: CCS_NORMAL,
      exiting: 1'b0, cnt: '0, strap_qs: 1'b0, strap_done: 1'b0, from_halt: 1'b0,
      mgmt: 1'b0, flushing: 1'b0, ev_q: '0, pend: '0, addr_mask: 1'b0, probe_q: 1'b0,
      probe_seen: 1'b0, grant_ack: 1'b0, halt_cyc: 1'b0, svc: 1'b0, svc_ev: '0};

   ccs_dev_t s;
   ccs_dev_t n;
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] rise;
   logic stop_on;
   logic brk;
   ccs_state_t lp;

   // ==========================================================
   // event edges
   assign ev = {~link.sys_reset_n, link.events};
   assign rise = ev & ~s.ev_q;
   assign stop_on = ~link.stop_clock_request_n;
   assign brk = |rise;
   assign lp = s.strap_qs ? CCS_QUICK_START : CCS_STOP_GRANT;

   // ==========================================================
   // next-state logic
   always_comb begin
      n = s;
      n.grant_ack = 1'b0;
      n.halt_cyc = 1'b0;
      n.svc = 1'b0;
      n.svc_ev = '0;
      n.ev_q = ev;
      // strap caught after release and again while the reset pin is held
      if (!s.strap_done || !link.sys_reset_n) begin
         n.strap_qs = ~link.quick_start_strap_n;
         n.strap_done = 1'b1;
      end
      if (s.mgmt && mgmt_exit_i) begin
         n.mgmt = 1'b0;
         if (mgmt_to_halt_i) begin
            n.st = CCS_AUTO_HALT;                              // no halt cycle
         end
      end
      if (s.flushing && flush_done_i) begin
         n.flushing = 1'b0;                                    // back in halt silently
      end
      if (s.exiting) begin
         // timed exit; the state is held until the count runs out
         n.cnt = s.cnt - 1'b1;
         if (s.cnt == CNT_W'(1)) begin
            n.exiting = 1'b0;
            n.st = s.tgt;
            if (s.tgt == CCS_NORMAL) begin
               n.svc = |s.pend;                                // one of each serviced
               n.svc_ev = s.pend;
               n.pend = '0;
            end
         end
      end else begin
         case (s.st)
            CCS_NORMAL: begin
               if (halt_instruction_i) begin
                  n.st = CCS_AUTO_HALT;
                  n.halt_cyc = 1'b1;
               end else if (stop_on) begin
                  n.st = lp;                                   // sleep ignored here
                  n.grant_ack = 1'b1;
                  n.from_halt = 1'b0;
               end
            end
            CCS_AUTO_HALT: begin
               n.addr_mask = ~link.addr20_mask_n;
               n.probe_q = ~link.probe_request_n;
               if (~link.probe_request_n && !s.probe_q) begin
                  n.probe_seen = ~s.probe_seen;                // toggles on each probe
               end
               if (rise[EV_FLUSH]) begin
                  n.flushing = 1'b1;
               end else if (brk) begin
                  n.exiting = 1'b1;
                  n.cnt = EXIT_CNT;
                  n.tgt = CCS_NORMAL;
                  n.mgmt = rise[EV_MGMT] | s.mgmt;
               end else if (stop_on && !s.flushing) begin
                  n.st = lp;
                  n.grant_ack = 1'b1;
                  n.from_halt = 1'b1;
               end else if (link.snoop_req) begin
                  n.st = CCS_SNOOP;
                  n.prev = CCS_AUTO_HALT;
               end
            end
            CCS_STOP_GRANT: begin
               n.pend = s.pend | rise[PEND_W-1:0];
               if (rise[EV_RESET]) begin
                  n.pend = '0;                                 // init, stay put
               end else if (rise[EV_BUS_INIT] || rise[EV_FLUSH]) begin
                  // service in normal; normal re-enters stop grant if still asked
                  n.exiting = 1'b1;
                  n.cnt = EXIT_CNT;
                  n.tgt = CCS_NORMAL;
               end else if (!stop_on) begin
                  n.exiting = 1'b1;
                  n.cnt = EXIT_CNT;
                  n.tgt = s.from_halt ? CCS_AUTO_HALT : CCS_NORMAL;
               end else if (!link.sleep_request_n) begin
                  n.st = CCS_SLEEP;
               end else if (link.snoop_req) begin
                  n.st = CCS_SNOOP;
                  n.prev = CCS_STOP_GRANT;
               end
            end
            CCS_QUICK_START: begin
               if (rise[EV_RESET]) begin
                  n.pend = '0;
               end else if (!link.bus_clock_on) begin
                  n.st = CCS_DEEP_SLEEP;
                  n.prev = CCS_QUICK_START;
                  n.cnt = '0;
               end else if (!stop_on) begin
                  n.exiting = 1'b1;                            // only way out
                  n.cnt = EXIT_CNT;
                  n.tgt = s.from_halt ? CCS_AUTO_HALT : CCS_NORMAL;
               end else if (link.snoop_req && !link.priority_bus_request_n) begin
                  n.st = CCS_SNOOP;                            // immediate
                  n.prev = CCS_QUICK_START;
               end
            end
            CCS_SNOOP: begin
               if (s.prev == CCS_STOP_GRANT) begin
                  n.pend = s.pend | rise[PEND_W-1:0];
               end
               // bus quiet: no snoop and no priority agent holding the bus
               if (!link.snoop_req && link.priority_bus_request_n) begin
                  n.exiting = 1'b1;
                  n.cnt = SNOOP_CNT;
                  n.tgt = s.prev;
               end
            end
            CCS_SLEEP: begin
               if (rise[EV_RESET]) begin
                  n.st = CCS_NORMAL;                           // system drops stop too
                  n.pend = '0;
               end else if (!link.bus_clock_on) begin
                  n.st = CCS_DEEP_SLEEP;
                  n.prev = CCS_SLEEP;
                  n.cnt = '0;
               end else if (link.sleep_request_n) begin
                  n.exiting = 1'b1;
                  n.cnt = EXIT_CNT;
                  n.tgt = CCS_STOP_GRANT;
               end
            end
            CCS_DEEP_SLEEP: begin
               // reset is not honoured here; the system must hold it off
               if (link.bus_clock_on) begin
                  n.cnt = s.cnt + 1'b1;                        // lock timer
                  if (s.cnt == LOCK_CNT - 1'b1) begin
                     n.st = s.prev;
                     n.cnt = '0;
                  end
               end else begin
                  n.cnt = '0;                                  // clock stopped again
               end
            end
            default: begin
               n.st = CCS_NORMAL;
            end
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   // ==========================================================
   // outputs
   assign link.clk_state = s.st;
   assign link.stop_grant_ack = s.grant_ack;
   assign link.halt_cycle = s.halt_cyc;
   assign link.snoop_busy = (s.st == CCS_SNOOP);
   assign core_clk_run_o = (s.st == CCS_NORMAL) && !s.exiting;
   assign sys_mgmt_mode_o = s.mgmt;
   assign flush_busy_o = s.flushing;
   assign addr20_mask_o = s.addr_mask;
   assign probe_seen_o = s.probe_seen;
   assign svc_o = s.svc;
   assign svc_events_o = s.svc_ev;
endmodule : ccs_dev

// File: ccs_sys.sv
// Purpose: system logic end of the clock-state link (stop, sleep, bus clock)
// Assumes: same clock as the device end
// Notes: freezes inputs the device must not see change in its idle states
`timescale 1ns/1ps
module ccs_sys
   import ccs_pkg::*;
#(
   parameter bit SINGLE_CPU = 1'b1,
   parameter bit QS_WANTED = 1'b1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // link
   ccs_link_if.sys link,
   // user side
   input wire logic stop_req_i,
   input wire logic sleep_req_i,
   input wire logic deep_req_i,
   input wire logic reset_req_i,
   input wire logic [EV_W-2:0] events_i,
   input wire logic addr20_mask_i,
   input wire logic probe_req_i,
   input wire logic snoop_i,
   input wire logic priority_req_i,
   output logic frozen_o,
   output logic maskable_irq_msg_ok_o
);
   // ==========================================================
   // state record
   typedef struct packed {
      logic stop;
      logic sleep;
      logic clk_on;
      logic rst;
      logic qs_hold;                // device sits in quick start, its snoop or its deep sleep
      logic [EV_W-2:0] ev;
      logic addr_mask;
      logic probe;
   } ccs_sys_t;

   localparam ccs_sys_t RST = '{stop: 1'b0, sleep: 1'b0, clk_on: 1'b1, rst: 1'b0,
      qs_hold: 1'b0, ev: '0, addr_mask: 1'b0, probe: 1'b0};

   ccs_sys_t s;
   ccs_sys_t n;
   logic in_sleep;
   logic in_deep;
   logic frozen;

   assign in_sleep = (link.clk_state == CCS_SLEEP) || s.sleep;
   assign in_deep = (link.clk_state == CCS_DEEP_SLEEP);
   assign frozen = s.qs_hold || in_sleep || in_deep;

   // ==========================================================
   // next-state logic
   always_comb begin
      n = s;
      if (link.clk_state == CCS_QUICK_START) begin
         n.qs_hold = 1'b1;
      end else if (link.clk_state == CCS_NORMAL || link.clk_state == CCS_AUTO_HALT) begin
         n.qs_hold = 1'b0;
      end
      if (!frozen) begin
         n.ev = events_i;
         n.addr_mask = addr20_mask_i;
         n.probe = probe_req_i;
      end
      n.rst = reset_req_i && !in_deep;
      n.stop = stop_req_i;
      // sleep is asked only in stop grant and held while there
      n.sleep = sleep_req_i && (link.clk_state == CCS_STOP_GRANT || s.sleep);
      if (reset_req_i && in_sleep) begin
         n.sleep = 1'b0;
         n.stop = 1'b0;
      end
      // bus clock stops only from sleep or quick start, restarts on demand
      if (!s.clk_on) begin
         n.clk_on = !deep_req_i;
      end else if (deep_req_i && (link.clk_state == CCS_SLEEP ||
                                  link.clk_state == CCS_QUICK_START)) begin
         n.clk_on = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   // ==========================================================
   // link drive; stop and sleep removal on a reset request in sleep act at once on the pins
   assign link.stop_clock_request_n = ~(s.stop && !(reset_req_i && in_sleep));
   assign link.sleep_request_n = ~(s.sleep && !(reset_req_i && in_sleep));
   assign link.sys_reset_n = ~s.rst;
   assign link.quick_start_strap_n = ~(QS_WANTED && SINGLE_CPU);
   assign link.bus_clock_on = s.clk_on;                         // stopped low
   assign link.maskable_irq_ctrl_clock_on = s.clk_on && !in_sleep;
   assign link.priority_bus_request_n = ~priority_req_i;
   assign link.snoop_req = snoop_i && !(s.qs_hold && !priority_req_i);
   assign link.events = s.ev;
   assign link.addr20_mask_n = ~s.addr_mask;
   assign link.probe_request_n = ~s.probe;
   assign frozen_o = frozen;
   assign maskable_irq_msg_ok_o = !s.qs_hold;
endmodule : ccs_sys

// File: ccs_link_monitor.sv
// Purpose: watch the clock-state link between the device end and the system end
// Assumes: one clock domain; link signals arrive as plain inputs
// Notes: latency figures follow the hand-over contract of the device end
`timescale 1ns/1ps
module ccs_link_monitor
   import ccs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // system to device
   input wire logic stop_clock_request_n,
   input wire logic sleep_request_n,
   input wire logic quick_start_strap_n,
   input wire logic bus_clock_on,
   input wire logic priority_bus_request_n,
   input wire logic snoop_req,
   input wire logic [EV_W-2:0] events,
   // device to system
   input wire ccs_state_t clk_state,
   input wire logic stop_grant_ack,
   input wire logic halt_cycle
);
   localparam int LOCK_LO = PLL_LOCK_CYC - 3;
   localparam int LOCK_HI = PLL_LOCK_CYC + 3;
   ccs_state_t prior;
   int lock_cnt;
   // ==========================================================
   // helpers: last state outside snoop, cycles of running clock in deep sleep
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prior <= CCS_NORMAL;
         lock_cnt <= 0;
      end else begin
         prior <= (clk_state == CCS_SNOOP) ? prior : clk_state;
         lock_cnt <= (clk_state == CCS_DEEP_SLEEP && bus_clock_on) ? lock_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ==========================================================
   // properties
   property p_one_hot;
      $onehot(clk_state);
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("state code not one-hot");
   property p_enter;
      clk_state == CCS_NORMAL && $fell(stop_clock_request_n)
         |=> stop_grant_ack && clk_state inside {CCS_QUICK_START, CCS_STOP_GRANT};
   endproperty
   a_enter: assert property (p_enter) else $error("stop request not answered");
   property p_strap;
      clk_state == CCS_QUICK_START |-> !quick_start_strap_n;
   endproperty
   a_strap: assert property (p_strap) else $error("quick start against strap");
   property p_halt_cycle;
      halt_cycle |-> clk_state == CCS_AUTO_HALT && $past(clk_state) == CCS_NORMAL;
   endproperty
   a_halt_cycle: assert property (p_halt_cycle) else $error("stray halt cycle");
   property p_break;
      clk_state == CCS_AUTO_HALT && $rose(|events[EV_BUS_INIT:EV_NMI])
         |-> ##11 clk_state == CCS_NORMAL;
   endproperty
   a_break: assert property (p_break) else $error("break exit latency wrong");
   property p_qs_leave;
      clk_state == CCS_QUICK_START && $rose(stop_clock_request_n)
         |-> ##11 clk_state inside {CCS_NORMAL, CCS_AUTO_HALT};
   endproperty
   a_qs_leave: assert property (p_qs_leave) else $error("quick start exit late");
   property p_qs_hold;
      $past(clk_state) == CCS_QUICK_START && clk_state inside {CCS_NORMAL, CCS_AUTO_HALT}
         |-> $past(stop_clock_request_n, 11);
   endproperty
   a_qs_hold: assert property (p_qs_hold) else $error("quick start left early");
   property p_sleep_refused;
      clk_state inside {CCS_NORMAL, CCS_AUTO_HALT} && !sleep_request_n |=> clk_state != CCS_SLEEP;
   endproperty
   a_sleep_refused: assert property (p_sleep_refused) else $error("sleep taken");
   property p_snoop_in;
      clk_state == CCS_QUICK_START && snoop_req && !priority_bus_request_n
         |=> clk_state == CCS_SNOOP;
   endproperty
   a_snoop_in: assert property (p_snoop_in) else $error("snoop not entered");
   property p_snoop_out;
      clk_state == CCS_SNOOP && $fell(snoop_req)
         |-> ##2 clk_state == CCS_SNOOP ##1 clk_state == prior;
   endproperty
   a_snoop_out: assert property (p_snoop_out) else $error("snoop return wrong");
   property p_deep_in;
      clk_state inside {CCS_QUICK_START, CCS_SLEEP} && $fell(bus_clock_on)
         |-> ##[1:2] clk_state == CCS_DEEP_SLEEP;
   endproperty
   a_deep_in: assert property (p_deep_in) else $error("deep sleep not entered");
   property p_deep_out;
      $past(clk_state) == CCS_DEEP_SLEEP && clk_state != CCS_DEEP_SLEEP
         |-> $past(lock_cnt) inside {[LOCK_LO:LOCK_HI]}
            && clk_state inside {CCS_QUICK_START, CCS_SLEEP};
   endproperty
   a_deep_out: assert property (p_deep_out) else $error("deep sleep exit wrong");
   // main scenarios seen
   c_quick: cover property (stop_grant_ack && clk_state == CCS_QUICK_START);
   c_snoop: cover property (clk_state == CCS_SNOOP);
   c_deep: cover property (clk_state == CCS_DEEP_SLEEP && bus_clock_on);
   c_halt: cover property (halt_cycle);
endmodule : ccs_link_monitor

// File: tb.sv
// Purpose: drive both ends of the clock-state link and check state changes
// Assumes: both ends share the 100 MHz clock
// Notes: a queue holds expected states; a watcher pops one per observed change
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("Error %0t: %h vs %h", $time, (a), (e)); end end
module tb;
   import ccs_pkg::*;
   logic core_clk_i = 1'h0;
   logic arst_n_i = 1'h0;
   logic stop_req_i = 1'h0, sleep_req_i = 1'h0, deep_req_i = 1'h0, reset_req_i = 1'h0;
   logic addr20_mask_i = 1'h0, probe_req_i = 1'h0, snoop_i = 1'h0, priority_req_i = 1'h0;
   logic halt_instruction_i = 1'h0, mgmt_exit_i = 1'h0, mgmt_to_halt_i = 1'h0, flush_done_i = 1'h0;
   logic [EV_W-2:0] events_i = '0;
   logic sys_mgmt_mode_o, flush_busy_o, addr20_mask_o, probe_seen_o, maskable_irq_msg_ok_o;
   int fails = 0, checked = 0, cycles = 0, halts = 0, halts_exp = 0, n, b;
   ccs_state_t exp_q[$];
   ccs_state_t last = CCS_NORMAL;
   // ==========================================================
   // the two ends face each other across the link
   ccs_link_if link();
   ccs_dev i_ccs_dev (.core_clk_i, .arst_n_i, .link(link.dev), .halt_instruction_i, .mgmt_exit_i,
      .mgmt_to_halt_i, .flush_done_i, .core_clk_run_o(), .sys_mgmt_mode_o, .flush_busy_o,
      .addr20_mask_o, .probe_seen_o, .svc_o(), .svc_events_o());
   ccs_sys #(.SINGLE_CPU(1'h1), .QS_WANTED(1'h1)) i_ccs_sys (.core_clk_i, .arst_n_i,
      .link(link.sys), .stop_req_i, .sleep_req_i, .deep_req_i, .reset_req_i, .events_i,
      .addr20_mask_i, .probe_req_i, .snoop_i, .priority_req_i, .frozen_o(), .maskable_irq_msg_ok_o);
   ccs_link_monitor i_ccs_link_monitor (.core_clk_i, .arst_n_i,
      .stop_clock_request_n(link.stop_clock_request_n), .sleep_request_n(link.sleep_request_n),
      .quick_start_strap_n(link.quick_start_strap_n), .bus_clock_on(link.bus_clock_on),
      .priority_bus_request_n(link.priority_bus_request_n), .snoop_req(link.snoop_req),
      .events(link.events), .clk_state(link.clk_state), .stop_grant_ack(link.stop_grant_ack),
      .halt_cycle(link.halt_cycle));
   // clock
   initial forever #5 core_clk_i = ~core_clk_i;
   // ==========================================================
   // closing report, shared by the main sequence and the timeout
   task automatic wrap_up();
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // timeout: the run needs a few thousand cycles, mostly the lock delay
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end
   // watcher: sampled mid-cycle so the edge's updates have landed
   always @(negedge core_clk_i) begin
      if (arst_n_i && link.clk_state !== last) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("Error %0t: unexpected state %h", $time, link.clk_state);
         end else `CHK(link.clk_state, exp_q.pop_front())
         last = link.clk_state;
      end
      if (link.halt_cycle === 1'h1) halts++;
   end
   task automatic step(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask : step
   // note the next state, then wait for it; n counts edges taken
   task automatic expect_state(input ccs_state_t s, input int lim);
      exp_q.push_back(s);
      n = 0;
      @(negedge core_clk_i);
      while (link.clk_state !== s && n < lim) begin
         @(negedge core_clk_i);
         n++;
      end
      if (n == lim) begin
         fails++;
         $display("Error %0t: state %h not reached", $time, s);
      end
      @(posedge core_clk_i);
   endtask : expect_state
   task automatic halt_now();
      halts_exp++;
      halt_instruction_i <= 1'h1;
      step(1);
      halt_instruction_i <= 1'h0;
      expect_state(CCS_AUTO_HALT, 4);
   endtask : halt_now
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h2399757b));
      repeat (5) @(posedge core_clk_i);
      arst_n_i <= 1'h1;
      step(2);
      // sleep request outside stop grant must change nothing
      sleep_req_i <= 1'h1;
      step(6);
      sleep_req_i <= 1'h0;
      // quick start: reset inside it, priority snoop, deep sleep round trip
      stop_req_i <= 1'h1;
      expect_state(CCS_QUICK_START, 8);
      reset_req_i <= 1'h1;
      step(3);
      // message hold flag registers one edge after entry, so look a few edges later
      `CHK(maskable_irq_msg_ok_o, 1'h0)
      reset_req_i <= 1'h0;
      step(4);
      snoop_i <= 1'h1;
      priority_req_i <= 1'h1;
      expect_state(CCS_SNOOP, 4);
      step(2);
      snoop_i <= 1'h0;
      priority_req_i <= 1'h0;
      expect_state(CCS_QUICK_START, 8);
      deep_req_i <= 1'h1;
      expect_state(CCS_DEEP_SLEEP, 4);
      step(20);
      deep_req_i <= 1'h0;
      expect_state(CCS_QUICK_START, 4000);
      `CHK(n > PLL_LOCK_CYC - 4 && n < PLL_LOCK_CYC + 4, 1'h1)
      stop_req_i <= 1'h0;
      expect_state(CCS_NORMAL, 20);
      `CHK(n, EXIT_BUS_CLKS + 2)
      // auto halt: in-place services, stop request, management return
      halt_now();
      addr20_mask_i <= 1'h1;
      probe_req_i <= 1'h1;
      events_i[EV_FLUSH] <= 1'h1;
      step(4);
      `CHK({addr20_mask_o, probe_seen_o, flush_busy_o}, 3'h7)
      events_i[EV_FLUSH] <= 1'h0;
      flush_done_i <= 1'h1;
      step(1);
      flush_done_i <= 1'h0;
      step(3);
      `CHK(flush_busy_o, 1'h0)
      stop_req_i <= 1'h1;
      expect_state(CCS_QUICK_START, 8);
      stop_req_i <= 1'h0;
      expect_state(CCS_AUTO_HALT, 20);
      events_i[EV_MGMT] <= 1'h1;
      expect_state(CCS_NORMAL, 20);
      events_i[EV_MGMT] <= 1'h0;
      `CHK(sys_mgmt_mode_o, 1'h1)
      mgmt_to_halt_i <= 1'h1;
      mgmt_exit_i <= 1'h1;
      step(1);
      mgmt_exit_i <= 1'h0;
      expect_state(CCS_AUTO_HALT, 4);
      mgmt_to_halt_i <= 1'h0;
      // random break events out of auto halt, each followed by a new halt
      for (int k = 0; k < 6; k++) begin
         b = $urandom_range(0, 3);
         if (b == 3) b = EV_BUS_INIT;
         events_i[b] <= 1'h1;
         expect_state(CCS_NORMAL, 20);
         events_i[b] <= 1'h0;
         step($urandom_range(1, 4));
         halt_now();
      end
      step(4);
      `CHK(exp_q.size(), 0)
      `CHK(halts, halts_exp)
      wrap_up();
   end
endmodule : tb
